// ==== intertrip_command_exchange_tb.sv ====
`timescale 1ns/1ps
module intertrip_command_exchange_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        perm = 1'b0;
    logic        dir = 1'b0;
    logic [7:0]  cmd = 8'h00;
    logic        send = 1'b0;
    logic [9:0]  msg = 10'h000;
    logic [15:0] cur = 16'h0000;
    logic [7:0]  dly = 8'h00;
    logic [15:0] thr = 16'h0100;
    logic        ind_rst = 1'b0;
    logic        rx_v;
    logic [9:0]  rx_m;
    logic [9:0]  tx;
    logic [7:0]  cmd_rx;
    logic        trip;
    logic        cont;
    logic        p_ind;
    logic        d_ind;
    logic        timing;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #50 clk = ~clk;
    itce_peer i_peer (.clk_in(clk), .send_in(send), .msg_in(msg), .valid_out(rx_v), .rx_out(rx_m));
    itce_intertrip i_dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .PERM_INPUT_IN(perm), .DIRECT_INPUT_IN(dir),
        .CMD_TX_COND_IN(cmd), .RX_MSG_VALID_IN(rx_v), .RX_MSG_IN(rx_m), .LOCAL_CURRENT_IN(cur),
        .BASIC_CURRENT_THRESHOLD_IN(thr), .PERM_DELAY_MS_IN(dly), .INDICATION_RESET_IN(ind_rst),
        .TX_MSG_OUT(tx), .TRIP_3PH_OUT(trip), .DIRECT_CONTACT_OUT(cont), .CMD_RX_OUT(cmd_rx),
        .PERM_IND_OUT(p_ind), .DIRECT_IND_OUT(d_ind), .PERM_TIMING_OUT(timing));
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send_msg(input logic [9:0] m);
        msg = m;
        send = 1'b1;
        tick(1);
        send = 1'b0;
        tick(4);
    endtask
    initial
    begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        for (int i = 0; i < 8; i++)
        begin
            cmd = 8'h01 << i;
            perm = i[0];
            dir = i[1];
            tick(5);
            chk(tx, {cmd, dir, perm});
        end
        {cmd, dir, perm} = 10'h000;
        tick(5);
        chk(tx, 10'h000);
        $display("transmit test done");
        for (int i = 0; i < 8; i++)
        begin
            send_msg({8'h01 << i, 2'b10});
            chk({cmd_rx, cont, d_ind, trip}, {8'h01 << i, 3'b110});
        end
        send_msg(10'h000);
        chk({cont, d_ind}, 2'b01);
        ind_rst = 1'b1;
        tick(2);
        chk(d_ind, 1'b0);
        send_msg(10'h002);
        chk({cont, d_ind}, 2'b11);
        ind_rst = 1'b0;
        send_msg(10'h000);
        chk({cont, d_ind}, 2'b01);
        $display("receive test done");
        cur = 16'h0100;
        send_msg(10'h001);
        chk(trip, 1'b0);
        cur = 16'h0101;
        tick(3);
        chk({trip, p_ind}, 2'b11);
        send_msg(10'h000);
        chk({trip, timing}, 2'b00);
        // One ms keeps the run short; real settings sit far higher
        dly = 8'h01;
        send_msg(10'h001);
        tick(4990);
        chk({trip, timing}, 2'b01);
        tick(5050);
        chk(trip, 1'b1);
        send_msg(10'h000);
        chk({trip, timing, p_ind}, 3'b001);
        ind_rst = 1'b1;
        tick(2);
        chk({p_ind, d_ind}, 2'b00);
        $display("permissive test done");
        test_done();
    end
endmodule

// ==== itce_intertrip.v ====
`timescale 1ns/1ps
`include "itce_map.vh"

module itce_intertrip #(
    parameter CMD_BITS = `ITCE_CMD_BITS,
    parameter CUR_W    = `ITCE_CUR_W
) (
    input  wire                         CORE_CLK_IN,
    input  wire                         RESETN_IN,
    input  wire                         PERM_INPUT_IN,
    input  wire                         DIRECT_INPUT_IN,
    input  wire [CMD_BITS-1:0]          CMD_TX_COND_IN,
    input  wire                         RX_MSG_VALID_IN,
    input  wire [`ITCE_MSG_W-1:0]       RX_MSG_IN,
    input  wire [CUR_W-1:0]             LOCAL_CURRENT_IN,
    input  wire [CUR_W-1:0]             BASIC_CURRENT_THRESHOLD_IN,
    input  wire [`ITCE_PIT_DELAY_W-1:0] PERM_DELAY_MS_IN,
    input  wire                         INDICATION_RESET_IN,
    output reg  [`ITCE_MSG_W-1:0]       TX_MSG_OUT,
    output reg                          TRIP_3PH_OUT,
    output reg                          DIRECT_CONTACT_OUT,
    output reg  [CMD_BITS-1:0]          CMD_RX_OUT,
    output reg                          PERM_IND_OUT,
    output reg                          DIRECT_IND_OUT,
    output reg                          PERM_TIMING_OUT
);

    // Permissive timer states
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_TIMING = 2'h1;
    localparam [1:0] ST_DONE   = 2'h2;

    // Prescaler end value and longest allowed delay
    localparam [`ITCE_MS_CNT_W-1:0]    MS_LAST   = `ITCE_MS_LAST;
    localparam [`ITCE_PIT_DELAY_W-1:0] DELAY_MAX = `ITCE_PIT_DELAY_MAX_MS;

    // Opto inputs come from the field; pulses under about one clock may be lost
    reg [1:0]                    perm_sync;
    reg [1:0]                    direct_sync;

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            perm_sync <= 2'h0;
        end
        else
        begin
            perm_sync <= {perm_sync[0], PERM_INPUT_IN};
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            direct_sync <= 2'h0;
        end
        else
        begin
            direct_sync <= {direct_sync[0], DIRECT_INPUT_IN};
        end
    end

    // Received flags are held between messages; a message without the flag clears it
    reg                          rx_perm;
    reg                          rx_direct;

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rx_perm <= 1'b0;
        end
        else if (RX_MSG_VALID_IN)
        begin
            rx_perm <= RX_MSG_IN[`ITCE_MSG_PERM_BIT];
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rx_direct <= 1'b0;
        end
        else if (RX_MSG_VALID_IN)
        begin
            rx_direct <= RX_MSG_IN[`ITCE_MSG_DIRECT_BIT];
        end
    end

    // Each command bit has its own synchroniser and its own held receive flop;
    // no fixed meaning is applied here, the scheme map decides what a bit does
    wire [CMD_BITS-1:0]          cmd_tx_sync;
    wire [CMD_BITS-1:0]          cmd_rx_held;

    genvar g;
    generate
        for (g = 0; g < CMD_BITS; g = g + 1)
        begin : g_cmd
            reg [1:0] tx_sync;
            reg       rx_held;

            always @(posedge CORE_CLK_IN or negedge RESETN_IN)
            begin
                if (!RESETN_IN)
                begin
                    tx_sync <= 2'h0;
                    rx_held <= 1'b0;
                end
                else
                begin
                    tx_sync <= {tx_sync[0], CMD_TX_COND_IN[g]};
                    if (RX_MSG_VALID_IN)
                    begin
                        rx_held <= RX_MSG_IN[`ITCE_MSG_CMD_LSB + g];
                    end
                end
            end

            assign cmd_tx_sync[g] = tx_sync[1];
            assign cmd_rx_held[g] = rx_held;
        end
    endgenerate

    // Transmit message: each bit follows its own programmed condition
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            TX_MSG_OUT <= {`ITCE_MSG_W{1'b0}};
        end
        else
        begin
            TX_MSG_OUT[`ITCE_MSG_PERM_BIT]              <= perm_sync[1];
            TX_MSG_OUT[`ITCE_MSG_DIRECT_BIT]            <= direct_sync[1];
            TX_MSG_OUT[`ITCE_MSG_CMD_LSB +: CMD_BITS]   <= cmd_tx_sync;
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            CMD_RX_OUT <= {CMD_BITS{1'b0}};
        end
        else
        begin
            CMD_RX_OUT <= cmd_rx_held;
        end
    end

    // Delay setting is clamped so an out-of-range value never stretches the timer
    reg [`ITCE_PIT_DELAY_W-1:0]  delay_ms;

    always @*
    begin
        if (PERM_DELAY_MS_IN > DELAY_MAX)
        begin
            delay_ms = DELAY_MAX;
        end
        else
        begin
            delay_ms = PERM_DELAY_MS_IN;
        end
    end

    reg [1:0]                    state;
    reg [1:0]                    next_state;
    reg [`ITCE_MS_CNT_W-1:0]     sub_cnt;
    reg [`ITCE_PIT_DELAY_W-1:0]  ms_cnt;

    // The counters run only while timing continues, so a lost flag restarts them
    wire                         timer_run  = (state == ST_TIMING) && (next_state == ST_TIMING);
    wire                         ms_tick    = (sub_cnt == MS_LAST);
    wire                         timer_done = (ms_cnt >= delay_ms);
    wire                         current_ok = (LOCAL_CURRENT_IN > BASIC_CURRENT_THRESHOLD_IN);
    wire                         perm_trip  = (next_state == ST_DONE) && current_ok;

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (rx_perm)
                    next_state = ST_TIMING;
            ST_TIMING:
                if (!rx_perm)
                    next_state = ST_IDLE;
                else if (timer_done)
                    next_state = ST_DONE;
            ST_DONE:
                if (!rx_perm)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Prescaler: one wrap per millisecond of timing
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            sub_cnt <= {`ITCE_MS_CNT_W{1'b0}};
        end
        else if (!timer_run || ms_tick)
        begin
            sub_cnt <= {`ITCE_MS_CNT_W{1'b0}};
        end
        else
        begin
            sub_cnt <= sub_cnt + 1'b1;
        end
    end

    // Whole milliseconds; it clears after reaching the setting because the state leaves timing
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ms_cnt <= {`ITCE_PIT_DELAY_W{1'b0}};
        end
        else if (!timer_run)
        begin
            ms_cnt <= {`ITCE_PIT_DELAY_W{1'b0}};
        end
        else if (ms_tick)
        begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // Trip is a level while the flag stays and the current check holds
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            TRIP_3PH_OUT <= 1'b0;
        end
        else
        begin
            TRIP_3PH_OUT <= perm_trip;
        end
    end

    // Direct path has no check and no delay beyond the holding flop and the output flop
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            DIRECT_CONTACT_OUT <= 1'b0;
        end
        else
        begin
            DIRECT_CONTACT_OUT <= rx_direct;
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            PERM_TIMING_OUT <= 1'b0;
        end
        else
        begin
            PERM_TIMING_OUT <= (next_state == ST_TIMING);
        end
    end

    // Indications latch until reset; a new event wins over the reset
    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            PERM_IND_OUT <= 1'b0;
        end
        else if (perm_trip)
        begin
            PERM_IND_OUT <= 1'b1;
        end
        else if (INDICATION_RESET_IN)
        begin
            PERM_IND_OUT <= 1'b0;
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            DIRECT_IND_OUT <= 1'b0;
        end
        else if (rx_direct)
        begin
            DIRECT_IND_OUT <= 1'b1;
        end
        else if (INDICATION_RESET_IN)
        begin
            DIRECT_IND_OUT <= 1'b0;
        end
    end

endmodule

// ==== itce_map.vh ====
`ifndef ITCE_MAP_VH
`define ITCE_MAP_VH

// Permissive intertrip delay setting, in milliseconds
`define ITCE_PIT_DELAY_MAX_MS   8'hC8
`define ITCE_PIT_DELAY_RST_MS   8'h00
`define ITCE_PIT_DELAY_W        8
// Last prescaler count of one millisecond at a 10 MHz clock
`define ITCE_MS_LAST            14'h270F
`define ITCE_MS_CNT_W           14
// Outgoing message bit positions
`define ITCE_MSG_PERM_BIT       0
`define ITCE_MSG_DIRECT_BIT     1
`define ITCE_MSG_CMD_LSB        2
`define ITCE_MSG_W              10
// Number of user command bits
`define ITCE_CMD_BITS           8
// Current magnitude width
`define ITCE_CUR_W              16

`endif

// ==== itce_peer.sv ====
`timescale 1ns/1ps
module itce_peer (
    input  logic       clk_in,
    input  logic       send_in,
    input  logic [9:0] msg_in,
    output logic       valid_out = 1'b0,
    output logic [9:0] rx_out = 10'h000
);
    // Junk between messages so stale flags are never relied on
    always @(posedge clk_in)
    begin
        valid_out <= send_in;
        rx_out <= send_in ? msg_in : ~rx_out;
    end
endmodule

// ==== itce_sva.sv ====
`timescale 1ns/1ps
module itce_sva #(
    parameter CMD_BITS = 8
) (
    input wire                CORE_CLK_IN,
    input wire                RESETN_IN,
    input wire                PERM_INPUT_IN,
    input wire                DIRECT_INPUT_IN,
    input wire [CMD_BITS-1:0] CMD_TX_COND_IN,
    input wire                RX_MSG_VALID_IN,
    input wire [9:0]          RX_MSG_IN,
    input wire [15:0]         LOCAL_CURRENT_IN,
    input wire [15:0]         BASIC_CURRENT_THRESHOLD_IN,
    input wire                INDICATION_RESET_IN,
    input wire [9:0]          TX_MSG_OUT,
    input wire                TRIP_3PH_OUT,
    input wire                DIRECT_CONTACT_OUT,
    input wire [CMD_BITS-1:0] CMD_RX_OUT,
    input wire                PERM_IND_OUT,
    input wire                DIRECT_IND_OUT,
    input wire                PERM_TIMING_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence s_msg(b, v);
        RX_MSG_VALID_IN && RX_MSG_IN[b] == v;
    endsequence
    chk_perm_set: assert property (PERM_INPUT_IN [*3] |=> TX_MSG_OUT[0])
        else $error("permissive flag missing");
    chk_direct_set: assert property (DIRECT_INPUT_IN [*3] |=> TX_MSG_OUT[1])
        else $error("direct flag missing");
    chk_cmd_tx: assert property ($stable(CMD_TX_COND_IN) [*3] |=> TX_MSG_OUT[9:2] == $past(CMD_TX_COND_IN))
        else $error("command bits not sent");
    chk_direct_rx: assert property (RX_MSG_VALID_IN |-> ##2 DIRECT_CONTACT_OUT == $past(RX_MSG_IN[1], 2))
        else $error("direct contact wrong");
    chk_cmd_rx: assert property (RX_MSG_VALID_IN |-> ##2 CMD_RX_OUT == $past(RX_MSG_IN[9:2], 2))
        else $error("received commands wrong");
    chk_direct_ind: assert property (s_msg(1, 1'b1) |-> ##2 DIRECT_IND_OUT)
        else $error("direct indication missing");
    chk_perm_ind: assert property ($rose(TRIP_3PH_OUT) |-> ##[0:2] PERM_IND_OUT)
        else $error("permissive indication missing");
    chk_trip_clear: assert property (s_msg(0, 1'b0) |-> ##2 !TRIP_3PH_OUT && !PERM_TIMING_OUT)
        else $error("permissive not reset");
    chk_trip_current: assert property (TRIP_3PH_OUT |-> $past(LOCAL_CURRENT_IN) > $past(BASIC_CURRENT_THRESHOLD_IN))
        else $error("trip without current");
    chk_perm_ind_hold: assert property (PERM_IND_OUT && !INDICATION_RESET_IN |=> PERM_IND_OUT)
        else $error("permissive indication lost");
endmodule
bind itce_intertrip itce_sva #(.CMD_BITS(CMD_BITS)) i_sva (.*);
